// ---- rtl/assc_regs.vh ----
// register codes, field positions, reset values and sizes for the scan sequence block
`ifndef ASSC_REGS_VH
`define ASSC_REGS_VH
// ***************************************************************
// frame layout
// ***************************************************************
`define ASSC_FRAME_BITS 16
`define ASSC_CFG_BIT 15
`define ASSC_SEL_HI 15
`define ASSC_SEL_LO 11
`define ASSC_FIELD_HI 10
`define ASSC_FIELD_LO 3
// ***************************************************************
// select codes
// ***************************************************************
`define ASSC_HIGH_MASK_SELECT_CODE 5'h14
`define ASSC_LOW_MASK_SELECT_CODE 5'h15
`define ASSC_SEQUENCE_SELECT_CODE 5'h16
// ***************************************************************
// reset values and sizes
// ***************************************************************
`define ASSC_MASK_RESET 8'h00
`define ASSC_LENGTH_RESET 8'h00
`define ASSC_NIBBLE_BITS 4
`define ASSC_SEQ_DEPTH 256
`define ASSC_CHAN_ZERO 4'h0
`endif

// ---- rtl/assc_seq_mem.v ----
// channel sequence memory with registered read data
`timescale 1ns/1ps
module assc_seq_mem #(
  parameter DEPTH = 256,
  parameter AW = 8,
  parameter DW = 4
) (
  input wire clk_i,             // system clock
  input wire wr_en_i,           // write strobe
  input wire [AW-1:0] wr_addr_i, // write entry
  input wire [DW-1:0] wr_data_i, // channel id
  input wire [AW-1:0] rd_addr_i, // read entry
  output reg [DW-1:0] rd_data_o  // registered channel id
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // write port and registered read
  always @(posedge clk_i)
  begin
    if (wr_en_i)
      mem[wr_addr_i] <= wr_data_i;
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ---- rtl/assc_top.v ----
// frame decoder, scan masks and channel sequencer configuration
//
// Summary of operation
// - select code 10100 writes the high-input scan mask.
// - high mask bits 10:3 include inputs 15..8; reset zero.
// - select code 10101 writes the low-input scan mask.
// - low mask bits 10:3 include inputs 7..0; reset zero.
// - select code 10110 writes the sequence length register.
// - length bits 10:3 plus one gives 1 to 256 conversions.
// - first result after mode start belongs to first sequence entry.
// - shutdown request accepted during the last result read frame.
// - frame with MSB one is a configuration write.
// - frame with MSB zero is a mode control write.
// - mode write in sequence waits for conversion, starts at next select fall.
// - config write in sequence lets current conversion finish unchanged.
// - after config write mid-sequence, output invalid until mode write.
// - pattern frame carries 4-bit channel ids, one per entry.
// - missing or partial entries default to channel zero.
// - pattern bits beyond the length are discarded.
// - new pattern active by the next select fall after pattern frame.
`timescale 1ns/1ps
`include "assc_regs.vh"
module assc_top #(
  parameter DEPTH = `ASSC_SEQ_DEPTH,
  parameter AW = 8
) (
  input wire MCLK_I,              // 200 MHz system clock
  input wire RST_B_I,             // synchronous reset, active low
  input wire SCLK_I,              // serial clock from host
  input wire CS_B_I,              // chip select, active low
  input wire DIN_I,               // serial data in
  input wire CONV_BUSY_I,         // conversion in progress
  input wire CONV_DONE_I,         // conversion finished pulse
  input wire LAST_READ_I,         // frame reads final result of sequence
  input wire ENTRY_ADV_I,         // engine moves to next entry
  output reg [7:0] HIGH_MASK_O,   // include inputs 15..8
  output reg [7:0] LOW_MASK_O,    // include inputs 7..0
  output reg [7:0] SEQ_LEN_M1_O,  // sequence length minus one
  output reg [3:0] ENTRY_CHAN_O,  // channel of current entry
  output reg [15:0] MODE_WORD_O,  // mode control word in force
  output reg MODE_START_O,        // pulse: new mode instruction begins
  output reg SHUTDOWN_REQ_O,      // automatic shutdown requested
  output reg DOUT_VALID_O,        // serial output data is valid
  output reg PATTERN_LOAD_O       // pulse: new pattern active
);
  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  reg [2:0] sclk_meta_reg;
  reg [2:0] cs_meta_reg;
  reg [1:0] din_meta_reg;
  always @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      sclk_meta_reg <= 3'h0;
      cs_meta_reg <= 3'h7;
      din_meta_reg <= 2'h0;
    end
    else
    begin
      sclk_meta_reg <= {sclk_meta_reg[1:0], SCLK_I};
      cs_meta_reg <= {cs_meta_reg[1:0], CS_B_I};
      din_meta_reg <= {din_meta_reg[0], DIN_I};
    end
  end
  // edges seen from the second and third stages only
  wire sclk_rise = sclk_meta_reg[1] & ~sclk_meta_reg[2];
  wire cs_fall = ~cs_meta_reg[1] & cs_meta_reg[2];
  wire cs_rise = cs_meta_reg[1] & ~cs_meta_reg[2];
  wire cs_low = ~cs_meta_reg[1];
  wire din_s = din_meta_reg[1];

  // ***************************************************************
  // frame shifter
  // ***************************************************************
  localparam ST_CMD = 2'h0;
  localparam ST_LEN = 2'h1;
  localparam ST_PAT = 2'h2;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] shift_reg;
  reg [8:0] bit_cnt_reg;
  reg [3:0] nib_reg;
  reg [AW:0] wr_idx_reg;
  reg pat_done_reg;
  reg [8:0] load_len_reg;
  wire [15:0] shift_next = {shift_reg[14:0], din_s};
  wire nib_full = (bit_cnt_reg[1:0] == 2'h3);
  // pattern write: whole nibbles within the length only
  wire pat_wr = (state_reg == ST_PAT) && cs_low && sclk_rise && nib_full &&
                (wr_idx_reg < {1'b0, SEQ_LEN_M1_O} + {{AW{1'b0}}, 1'b1});
  // default fill of missing entries after the pattern frame ends
  wire fill_wr = (state_reg == ST_PAT) && pat_done_reg &&
                 (wr_idx_reg < {1'b0, SEQ_LEN_M1_O} + {{AW{1'b0}}, 1'b1});
  wire mem_wr = pat_wr | fill_wr;
  wire [3:0] mem_data = pat_wr ? {nib_reg[2:0], din_s} : `ASSC_CHAN_ZERO;
  // a pattern frame is never decoded as a register or mode write
  wire frame_end = cs_rise && (bit_cnt_reg >= 9'd16) && (state_reg != ST_PAT);
  wire [15:0] frame = shift_reg;
  wire [4:0] sel = frame[`ASSC_SEL_HI:`ASSC_SEL_LO];
  wire [7:0] field = frame[`ASSC_FIELD_HI:`ASSC_FIELD_LO];
  wire is_cfg = frame[`ASSC_CFG_BIT];
  wire is_mode = ~frame[`ASSC_CFG_BIT];

  // sequencer state transitions
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_CMD:
        if (frame_end && is_cfg && sel == `ASSC_SEQUENCE_SELECT_CODE)
          state_next = ST_LEN;
      ST_LEN:
        if (cs_fall)
          state_next = ST_PAT;
      ST_PAT:
        if (pat_done_reg && !fill_wr)
          state_next = ST_CMD;
      default:
        state_next = ST_CMD;
    endcase
  end

  // shift, count and pattern indexing
  always @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      state_reg <= ST_CMD;
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 9'h000;
      nib_reg <= 4'h0;
      wr_idx_reg <= {(AW+1){1'b0}};
      pat_done_reg <= 1'b0;
      load_len_reg <= 9'h000;
    end
    else
    begin
      state_reg <= state_next;
      if (cs_fall)
      begin
        bit_cnt_reg <= 9'h000;
        pat_done_reg <= 1'b0;
        if (state_reg == ST_LEN)
          wr_idx_reg <= {(AW+1){1'b0}};
      end
      else if (cs_low && sclk_rise)
      begin
        shift_reg <= shift_next;
        nib_reg <= {nib_reg[2:0], din_s};
        if (bit_cnt_reg != 9'h1ff)
          bit_cnt_reg <= bit_cnt_reg + 9'h001;
      end
      if (mem_wr)
        wr_idx_reg <= wr_idx_reg + {{AW{1'b0}}, 1'b1};
      // a partial nibble at frame end is dropped and filled with zero
      if (cs_rise && state_reg == ST_PAT)
        pat_done_reg <= 1'b1;
      if (state_reg == ST_PAT && pat_done_reg && !fill_wr)
        load_len_reg <= wr_idx_reg;
    end
  end

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  reg in_seq_reg;
  reg cfg_dirty_reg;
  reg mode_pend_reg;
  reg [15:0] mode_hold_reg;
  always @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      HIGH_MASK_O <= `ASSC_MASK_RESET;
      LOW_MASK_O <= `ASSC_MASK_RESET;
      SEQ_LEN_M1_O <= `ASSC_LENGTH_RESET;
      MODE_WORD_O <= 16'h0000;
      mode_hold_reg <= 16'h0000;
      mode_pend_reg <= 1'b0;
      cfg_dirty_reg <= 1'b0;
      SHUTDOWN_REQ_O <= 1'b0;
    end
    else
    begin
      // writes touch only the selected register
      if (frame_end && is_cfg)
      begin
        case (sel)
          `ASSC_HIGH_MASK_SELECT_CODE: HIGH_MASK_O <= field;
          `ASSC_LOW_MASK_SELECT_CODE: LOW_MASK_O <= field;
          `ASSC_SEQUENCE_SELECT_CODE: SEQ_LEN_M1_O <= field;
          default: ;
        endcase
        if (in_seq_reg)
          cfg_dirty_reg <= 1'b1;
      end
      // mode write is held until a select fall with no conversion busy
      if (frame_end && is_mode)
      begin
        mode_hold_reg <= frame;
        mode_pend_reg <= 1'b1;
        cfg_dirty_reg <= 1'b0;
      end
      else if (cs_fall && mode_pend_reg && !CONV_BUSY_I)
      begin
        MODE_WORD_O <= mode_hold_reg;
        mode_pend_reg <= 1'b0;
      end
      // each mode frame sets or clears the request, which stands until the next
      if (frame_end && is_mode)
        SHUTDOWN_REQ_O <= LAST_READ_I;
    end
  end

  // ***************************************************************
  // sequence readout and status
  // ***************************************************************
  reg [AW-1:0] rd_idx_reg;
  wire [3:0] rd_chan;
  wire mode_go = cs_fall && mode_pend_reg && !CONV_BUSY_I;
  always @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      rd_idx_reg <= {AW{1'b0}};
      in_seq_reg <= 1'b0;
      MODE_START_O <= 1'b0;
      DOUT_VALID_O <= 1'b0;
      PATTERN_LOAD_O <= 1'b0;
      ENTRY_CHAN_O <= `ASSC_CHAN_ZERO;
    end
    else
    begin
      MODE_START_O <= mode_go;
      PATTERN_LOAD_O <= (state_reg == ST_PAT) && pat_done_reg && !fill_wr;
      ENTRY_CHAN_O <= rd_chan;
      if (mode_go)
      begin
        rd_idx_reg <= {AW{1'b0}};
        in_seq_reg <= 1'b1;
      end
      else if (ENTRY_ADV_I)
        rd_idx_reg <= (rd_idx_reg == SEQ_LEN_M1_O) ? {AW{1'b0}} : rd_idx_reg + 1'b1;
      if (CONV_DONE_I && LAST_READ_I)
        in_seq_reg <= 1'b0;
      DOUT_VALID_O <= !cfg_dirty_reg && !(frame_end && is_cfg && in_seq_reg);
    end
  end

  // ***************************************************************
  // pattern store
  // ***************************************************************
  assc_seq_mem #(
    .DEPTH(DEPTH),
    .AW(AW),
    .DW(`ASSC_NIBBLE_BITS)
  ) u_mem (
    .clk_i(MCLK_I),
    .wr_en_i(mem_wr),
    .wr_addr_i(wr_idx_reg[AW-1:0]),
    .wr_data_i(mem_data),
    .rd_addr_i(rd_idx_reg),
    .rd_data_o(rd_chan)
  );
endmodule

// ---- tb/assc_props.sv ----
// concurrent checks on the scan sequence block ports
`timescale 1ns/1ps
module assc_props (
  input wire MCLK_I, // system clock
  input wire RST_B_I, // sync reset, active low
  input wire CS_B_I, // chip select
  input wire LAST_READ_I, // last result frame
  input wire [7:0] HIGH_MASK_O, // inputs 15..8
  input wire [7:0] LOW_MASK_O, // inputs 7..0
  input wire [7:0] SEQ_LEN_M1_O, // length minus one
  input wire [15:0] MODE_WORD_O, // mode word
  input wire MODE_START_O, // mode launch pulse
  input wire SHUTDOWN_REQ_O, // shutdown level
  input wire DOUT_VALID_O, // output data valid
  input wire PATTERN_LOAD_O // pattern load pulse
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  // ***************************************************************
  // register, pulse and status relations
  // ***************************************************************
  reset_clears_regs_a: assert property ($rose(RST_B_I) |-> HIGH_MASK_O == 8'h00 &&
    LOW_MASK_O == 8'h00 && SEQ_LEN_M1_O == 8'h00) else $error("registers not cleared by reset");
  high_after_frame_a: assert property ($changed(HIGH_MASK_O) |-> CS_B_I)
    else $error("high mask moved inside a frame");
  low_after_frame_a: assert property ($changed(LOW_MASK_O) |-> CS_B_I)
    else $error("low mask moved inside a frame");
  len_after_frame_a: assert property ($changed(SEQ_LEN_M1_O) |-> CS_B_I)
    else $error("length moved inside a frame");
  start_one_cycle_a: assert property (MODE_START_O |=> !MODE_START_O)
    else $error("mode start longer than one cycle");
  start_in_frame_a: assert property (MODE_START_O |-> !CS_B_I)
    else $error("mode start outside a select low");
  load_before_fall_a: assert property (PATTERN_LOAD_O |-> CS_B_I ##1 !PATTERN_LOAD_O)
    else $error("pattern load late or too long");
  shutdown_cause_a: assert property ($rose(SHUTDOWN_REQ_O) |-> $past(LAST_READ_I))
    else $error("shutdown without last read frame");
  valid_drop_a: assert property ($fell(DOUT_VALID_O) |-> CS_B_I)
    else $error("valid dropped inside a frame");
  mode_msb_zero_a: assert property ($changed(MODE_WORD_O) |-> !MODE_WORD_O[15])
    else $error("mode word with top bit set");
  cover property (MODE_START_O);
  cover property (PATTERN_LOAD_O);
  cover property ($fell(DOUT_VALID_O));
endmodule
bind assc_top assc_props i_assc_props (.MCLK_I, .RST_B_I, .CS_B_I, .LAST_READ_I, .HIGH_MASK_O,
  .LOW_MASK_O, .SEQ_LEN_M1_O, .MODE_WORD_O, .MODE_START_O, .SHUTDOWN_REQ_O, .DOUT_VALID_O,
  .PATTERN_LOAD_O);

// ---- tb/assc_host.sv ----
// host serial master model sending frames to the scan sequence block
`timescale 1ns/1ps
module assc_host (
  input logic clk_i, // system clock, keeps link edges off its rising edge
  output logic sclk_o, // serial clock, still between frames
  output logic cs_b_o, // chip select, active low
  output logic din_o // serial data
);
  initial
  begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    din_o = 1'b0;
  end
  // ***************************************************************
  // one frame of n bits, msb first, then a long idle gap
  // ***************************************************************
  task automatic xfer(input logic [15:0] w, input int n);
    @(negedge clk_i);
    #1.25;
    cs_b_o = 1'b0;
    #24;
    for (int i = n - 1; i >= 0; i--)
    begin
      din_o = w[i];
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
    #24 cs_b_o = 1'b1;
    din_o = ~din_o; // released line shows no stale level
    #1500;
  endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the scan sequence block
`timescale 1ns/1ps
module tb;
  logic mclk = 0, rst_b = 0, busy = 0, done = 0, last = 0, adv = 0;
  wire sclk, cs_b, din, start, shut, valid, load;
  wire [7:0] hm, lm, len;
  wire [3:0] chan;
  wire [15:0] mw;
  int err_total = 0, compares = 0, n_start = 0, n_load = 0, cyc = 0, k;
  initial forever #2.5 mclk = ~mclk;
  assc_host i_assc_host (.clk_i(mclk), .sclk_o(sclk), .cs_b_o(cs_b), .din_o(din));
  assc_top i_assc_top (.MCLK_I(mclk), .RST_B_I(rst_b), .SCLK_I(sclk), .CS_B_I(cs_b),
    .DIN_I(din), .CONV_BUSY_I(busy), .CONV_DONE_I(done), .LAST_READ_I(last),
    .ENTRY_ADV_I(adv), .HIGH_MASK_O(hm), .LOW_MASK_O(lm), .SEQ_LEN_M1_O(len),
    .ENTRY_CHAN_O(chan), .MODE_WORD_O(mw), .MODE_START_O(start), .SHUTDOWN_REQ_O(shut),
    .DOUT_VALID_O(valid), .PATTERN_LOAD_O(load));
  // pulse counters and hang guard
  always @(posedge mclk)
  begin
    n_start += (start === 1'b1);
    n_load += (load === 1'b1);
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish;
    end
  end
  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic mode(input logic [15:0] w);
    i_assc_host.xfer(w, 16);
    i_assc_host.xfer(16'h0000, 4); // short frame, only its select fall counts
  endtask
  task automatic step;
    @(posedge mclk) adv <= 1'b1;
    @(posedge mclk) adv <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task tally_and_finish;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ***************************************************************
  // scenarios
  // ***************************************************************
  task t_masks;
    check({hm, lm}, 16'h0000);
    check(len, 8'h00);
    i_assc_host.xfer({5'h14, 8'h5a, 3'h7}, 16);
    check({hm, lm}, 16'h5a00);
    i_assc_host.xfer({5'h15, 8'hc3, 3'h0}, 16);
    check({hm, lm}, 16'h5ac3);
    i_assc_host.xfer({5'h11, 8'hff, 3'h0}, 16);
    i_assc_host.xfer({5'h14, 8'hff, 3'h0}, 15);
    check({hm, lm, len}, 24'h5ac300);
    $display("test masks done");
  endtask
  task t_seq;
    k = n_load;
    i_assc_host.xfer({5'h16, 8'h03, 3'h5}, 16);
    check(len, 8'h03);
    i_assc_host.xfer(16'h00e7, 10); // entries 3 and 9, then half an entry
    check(n_load, k + 1);
    mode(16'h0123);
    check(chan, 4'h3);
    step;
    check(chan, 4'h9);
    step;
    check(chan, 4'h0);
    step;
    check(chan, 4'h0);
    i_assc_host.xfer({5'h16, 8'h01, 3'h0}, 16);
    i_assc_host.xfer(16'ha5ff, 16); // entries a and 5, the rest beyond the length
    check({hm, len}, 16'h5a01);
    mode(16'h0123);
    check(chan, 4'ha);
    step;
    check(chan, 4'h5);
    step;
    check(chan, 4'ha);
    $display("test sequence done");
  endtask
  task t_mode;
    k = n_start;
    @(posedge mclk) busy <= 1'b1;
    mode(16'h0456);
    check(n_start, k);
    @(posedge mclk) busy <= 1'b0;
    i_assc_host.xfer(16'h0000, 4);
    check(n_start, k + 1);
    check(mw, 16'h0456);
    check(shut, 1'b0);
    @(posedge mclk) busy <= 1'b1;
    i_assc_host.xfer({5'h15, 8'h0f, 3'h0}, 16);
    check(valid, 1'b0);
    @(posedge mclk) busy <= 1'b0;
    done <= 1'b1;
    @(posedge mclk) done <= 1'b0;
    last <= 1'b1;
    mode(16'h0789);
    @(posedge mclk) last <= 1'b0;
    check({shut, valid}, 2'b11);
    $display("test mode done");
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    check(valid, 1'b1);
    t_masks;
    t_seq;
    t_mode;
    tally_and_finish;
  end
endmodule
